// ==== design/pam_pkg.sv ====
// Constants shared by the port alternate-function multiplexer
package pam_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  ADDR_A_AF       = 8'h00;
    localparam logic [7:0]  ADDR_B_AF       = 8'h04;
    localparam logic [7:0]  ADDR_C_AF       = 8'h08;
    localparam logic [7:0]  ADDR_B_SEL_LO   = 8'h0C;
    localparam logic [7:0]  ADDR_B_SEL_HI   = 8'h10;
    localparam logic [7:0]  ADDR_C_SEL_LO   = 8'h14;
    localparam logic [7:0]  ADDR_C_SEL_HI   = 8'h18;
    localparam logic [7:0]  ADDR_STATUS     = 8'h1C;
    localparam logic [7:0]  ADDR_PADS       = 8'h20;

    // ------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE        = 8'h00;
    localparam logic [7:0]  ALL_INPUT       = 8'hFF;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // ------------------------------------------------------------
    // Package variant strap codes
    // ------------------------------------------------------------
    localparam logic [1:0]  VAR_8PIN        = 2'h0;
    localparam logic [1:0]  VAR_20PIN       = 2'h1;
    localparam logic [1:0]  VAR_28PIN       = 2'h2;

    // ------------------------------------------------------------
    // Pin positions
    // ------------------------------------------------------------
    localparam int unsigned PIN_A_T0        = 0;
    localparam int unsigned PIN_A_CLK8      = 1;
    localparam int unsigned PIN_A_T1        = 6;
    localparam int unsigned PIN_B_CLK       = 3;
    localparam int unsigned PIN_B_AN7       = 4;
    localparam int unsigned PIN_B_VREF      = 5;
    localparam int unsigned PIN_C_VREF      = 2;

    // Status word fields
    localparam int unsigned ST_EXTCLK_SEL   = 0;
    localparam int unsigned ST_VAR_LSB      = 4;

endpackage : pam_pkg

// ==== design/pam_port_alt_mux.sv ====
// Alternate-function pin multiplexer for ports A, B and C with APB registers
`timescale 1ns/1ps
module pam_port_alt_mux (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Package variant strap
    input  wire logic [1:0]  pkgVariant,
    // Pads: input, output, output enable (low drives)
    input  wire logic [7:0]  padInA,
    output logic      [7:0]  padOutA,
    output logic      [7:0]  padOeNA,
    input  wire logic [7:0]  padInB,
    output logic      [7:0]  padOutB,
    output logic      [7:0]  padOeNB,
    input  wire logic [7:0]  padInC,
    output logic      [7:0]  padOutC,
    output logic      [7:0]  padOeNC,
    // General-purpose port side
    input  wire logic [7:0]  gpioOutA,
    input  wire logic [7:0]  gpioOeNA,
    input  wire logic [7:0]  gpioOutB,
    input  wire logic [7:0]  gpioOeNB,
    input  wire logic [7:0]  gpioOutC,
    input  wire logic [7:0]  gpioOeNC,
    output logic      [7:0]  gpioInA,
    output logic      [7:0]  gpioInB,
    output logic      [7:0]  gpioInC,
    // Timers
    input  wire logic        timer0Output,
    input  wire logic        timer0OutComp,
    input  wire logic        timer0InMode,
    input  wire logic        timer1Output,
    input  wire logic        timer1OutComp,
    input  wire logic        timer1InMode,
    output logic             timer0Input,
    output logic             timer1Input,
    // UART / infrared
    input  wire logic        uart0DriverEnable,
    input  wire logic        uart0Transmit,
    output logic             uart0ClearToSend,
    output logic             uart0Receive,
    // LED sink request for port C pins 0..2
    input  wire logic [2:0]  ledSinkOn,
    // Analogue and clock routing
    output logic      [4:0]  analogSelB,
    output logic             vrefSelB,
    output logic      [2:0]  analogSelC,
    output logic             vrefSelC,
    output logic             extClockIn,
    output logic             extClockSel
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  afA_reg;
    logic [7:0]  afB_reg;
    logic [7:0]  afC_reg;
    logic [7:0]  selLoB_reg;
    logic [7:0]  selHiB_reg;
    logic [7:0]  selLoC_reg;
    logic [7:0]  selHiC_reg;
    logic [25:0] syncAll;
    logic [7:0]  syncA;
    logic [7:0]  syncB;
    logic [7:0]  syncC;
    logic [1:0]  variantSync;
    logic        apbAccess;
    logic        apbWrite;
    logic        addrHit;
    logic [31:0] rdata_next;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Enable gated by a set-select value; enable clear always wins
    function automatic logic afPick(input logic en, input logic sel, input logic want);
        afPick = en & (sel == want);
    endfunction : afPick

    // Zero-extend a byte to a bus word
    function automatic logic [31:0] word8(input logic [7:0] b);
        word8 = {24'h00_0000, b};
    endfunction : word8

    // ------------------------------------------------------------
    // Input synchronisers: pads and strap are outside the domain
    // ------------------------------------------------------------
    pam_sync2 #(
        .WIDTH   (26)
    ) uSync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .asyncIn ({pkgVariant, padInC, padInB, padInA}),
        .syncOut (syncAll)
    );

    assign syncA       = syncAll[7:0];
    assign syncB       = syncAll[15:8];
    assign syncC       = syncAll[23:16];
    assign variantSync = syncAll[25:24];

    // ------------------------------------------------------------
    // APB slave: one wait state, pready and prdata from flops
    // ------------------------------------------------------------
    assign apbAccess = psel & penable & pready;
    assign apbWrite  = apbAccess & pwrite;

    // Address decode shared by read mux and error flag
    always_comb begin
        addrHit    = 1'b1;
        rdata_next = pam_pkg::ZERO_WORD;
        unique case (paddr)
            pam_pkg::ADDR_A_AF:     rdata_next = word8(afA_reg);
            pam_pkg::ADDR_B_AF:     rdata_next = word8(afB_reg);
            pam_pkg::ADDR_C_AF:     rdata_next = word8(afC_reg);
            pam_pkg::ADDR_B_SEL_LO: rdata_next = word8(selLoB_reg);
            pam_pkg::ADDR_B_SEL_HI: rdata_next = word8(selHiB_reg);
            pam_pkg::ADDR_C_SEL_LO: rdata_next = word8(selLoC_reg);
            pam_pkg::ADDR_C_SEL_HI: rdata_next = word8(selHiC_reg);
            pam_pkg::ADDR_STATUS: begin
                rdata_next[pam_pkg::ST_EXTCLK_SEL]                  = extClockSel;
                rdata_next[pam_pkg::ST_VAR_LSB +: 2]                = variantSync;
            end
            pam_pkg::ADDR_PADS:     rdata_next = {8'h00, syncC, syncB, syncA};
            default:                addrHit    = 1'b0;
        endcase
    end

    // Ready pulses in the second access cycle, so every transfer takes three edges
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= pam_pkg::ZERO_WORD;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rdata_next : pam_pkg::ZERO_WORD;
            pslverr <= psel & penable & ~pready & ~addrHit;
        end
    end

    // Port A enable register: single function per pin, no set-select
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            afA_reg <= pam_pkg::RST_BYTE;
        end else if (apbWrite && paddr == pam_pkg::ADDR_A_AF) begin
            afA_reg <= pwdata[7:0];
        end
    end

    // Port B enable and set-select registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            afB_reg    <= pam_pkg::RST_BYTE;
            selLoB_reg <= pam_pkg::RST_BYTE;
            selHiB_reg <= pam_pkg::RST_BYTE;
        end else if (apbWrite) begin
            if (paddr == pam_pkg::ADDR_B_AF) begin
                afB_reg <= pwdata[7:0];
            end
            if (paddr == pam_pkg::ADDR_B_SEL_LO) begin
                selLoB_reg <= pwdata[7:0];
            end
            // Stored for software only; nothing in the mux reads it
            if (paddr == pam_pkg::ADDR_B_SEL_HI) begin
                selHiB_reg <= pwdata[7:0];
            end
        end
    end

    // Port C enable and set-select registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            afC_reg    <= pam_pkg::RST_BYTE;
            selLoC_reg <= pam_pkg::RST_BYTE;
            selHiC_reg <= pam_pkg::RST_BYTE;
        end else if (apbWrite) begin
            if (paddr == pam_pkg::ADDR_C_AF) begin
                afC_reg <= pwdata[7:0];
            end
            if (paddr == pam_pkg::ADDR_C_SEL_LO) begin
                selLoC_reg <= pwdata[7:0];
            end
            if (paddr == pam_pkg::ADDR_C_SEL_HI) begin
                selHiC_reg <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Port A mux
    // ------------------------------------------------------------
    logic       is8Pin;
    logic       is28Pin;
    logic [7:0] outA_next;
    logic [7:0] oeNA_next;

    assign is8Pin  = (variantSync == pam_pkg::VAR_8PIN);
    assign is28Pin = (variantSync == pam_pkg::VAR_28PIN);

    // Each pin starts from the GPIO value; an enable bit hands it to its function
    always_comb begin
        outA_next = gpioOutA;
        oeNA_next = gpioOeNA;
        // Timer pins 0 and 6 follow the timer mode, not a register bit
        if (afA_reg[0]) begin
            outA_next[0] = timer0OutComp;
            oeNA_next[0] = timer0InMode;
        end
        if (afA_reg[1]) begin
            outA_next[1] = timer0Output;
            oeNA_next[1] = is8Pin;
        end
        if (afA_reg[2]) begin
            outA_next[2] = uart0DriverEnable;
            oeNA_next[2] = 1'b0;
        end
        if (afA_reg[3]) begin
            outA_next[3] = 1'b0;
            oeNA_next[3] = 1'b1;
        end
        if (afA_reg[4]) begin
            outA_next[4] = 1'b0;
            oeNA_next[4] = 1'b1;
        end
        if (afA_reg[5]) begin
            outA_next[5] = uart0Transmit;
            oeNA_next[5] = 1'b0;
        end
        if (afA_reg[6]) begin
            outA_next[6] = timer1OutComp;
            oeNA_next[6] = timer1InMode;
        end
        if (afA_reg[7]) begin
            outA_next[7] = timer1Output;
            oeNA_next[7] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Port B mux: only the low set-select register is consulted
    // ------------------------------------------------------------
    logic [7:0] outB_next;
    logic [7:0] oeNB_next;
    logic [4:0] anB_next;
    logic       vrefB_next;
    logic       clkB_next;

    // Analogue and reserved choices release the pad so no digital driver fights it
    always_comb begin
        outB_next  = gpioOutB;
        oeNB_next  = gpioOeNB;
        anB_next   = 5'h00;
        vrefB_next = 1'b0;
        clkB_next  = 1'b0;
        for (int i = 0; i < 8; i++) begin
            if (afB_reg[i]) begin
                outB_next[i] = 1'b0;
                oeNB_next[i] = 1'b1;
            end
        end
        for (int i = 0; i < 3; i++) begin
            anB_next[i] = afPick(afB_reg[i], selLoB_reg[i], 1'b1);
        end
        clkB_next = afPick(afB_reg[pam_pkg::PIN_B_CLK], selLoB_reg[pam_pkg::PIN_B_CLK], 1'b0);
        anB_next[3] = afPick(afB_reg[pam_pkg::PIN_B_CLK], selLoB_reg[pam_pkg::PIN_B_CLK], 1'b1);
        anB_next[4] = afPick(afB_reg[pam_pkg::PIN_B_AN7], selLoB_reg[pam_pkg::PIN_B_AN7], 1'b1);
        // Reference exists only on the largest package
        vrefB_next = is28Pin &
                     afPick(afB_reg[pam_pkg::PIN_B_VREF], selLoB_reg[pam_pkg::PIN_B_VREF], 1'b1);
    end

    // ------------------------------------------------------------
    // Port C mux: pins 0..2 decoded, higher pins stay GPIO here
    // ------------------------------------------------------------
    logic [7:0] outC_next;
    logic [7:0] oeNC_next;
    logic [2:0] anC_next;
    logic       vrefC_next;

    // LED drive sinks current by pulling low; otherwise the pad floats for analogue use
    always_comb begin
        outC_next  = gpioOutC;
        oeNC_next  = gpioOeNC;
        anC_next   = 3'h0;
        vrefC_next = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (afC_reg[i]) begin
                outC_next[i] = 1'b0;
                oeNC_next[i] = ~(selLoC_reg[i] & ledSinkOn[i]);
                anC_next[i]  = afPick(afC_reg[i], selLoC_reg[i], 1'b1) & ~ledSinkOn[i];
            end
        end
        // Reference on pin 2 only on the 20-pin package
        vrefC_next = (variantSync == pam_pkg::VAR_20PIN) & ~ledSinkOn[pam_pkg::PIN_C_VREF] &
                     afPick(afC_reg[pam_pkg::PIN_C_VREF], selLoC_reg[pam_pkg::PIN_C_VREF],
                            1'b1);
    end

    // ------------------------------------------------------------
    // External clock source select
    // ------------------------------------------------------------
    logic clkSel_next;
    logic ext_clock_in_next;

    // Small parts take the clock on port A pin 1, larger ones on port B pin 3
    always_comb begin
        if (is8Pin) begin
            clkSel_next = afA_reg[pam_pkg::PIN_A_CLK8];
            ext_clock_in_next  = clkSel_next & syncA[pam_pkg::PIN_A_CLK8];
        end else begin
            clkSel_next = clkB_next;
            ext_clock_in_next  = clkB_next & syncB[pam_pkg::PIN_B_CLK];
        end
    end

    // ------------------------------------------------------------
    // Output flops: pads
    // ------------------------------------------------------------

    // All pads float during reset; afterwards they follow the GPIO side until software enables a function
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            padOutA <= pam_pkg::RST_BYTE;
            padOeNA <= pam_pkg::ALL_INPUT;
            padOutB <= pam_pkg::RST_BYTE;
            padOeNB <= pam_pkg::ALL_INPUT;
            padOutC <= pam_pkg::RST_BYTE;
            padOeNC <= pam_pkg::ALL_INPUT;
        end else begin
            padOutA <= outA_next;
            padOeNA <= oeNA_next;
            padOutB <= outB_next;
            padOeNB <= oeNB_next;
            padOutC <= outC_next;
            padOeNC <= oeNC_next;
        end
    end

    // ------------------------------------------------------------
    // Output flops: peripheral inputs and routing flags
    // ------------------------------------------------------------

    // Inputs reach a peripheral only while its pin is handed over; idle level is low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer0Input      <= 1'b0;
            timer1Input      <= 1'b0;
            uart0ClearToSend <= 1'b0;
            uart0Receive     <= 1'b0;
        end else begin
            timer0Input      <= afA_reg[pam_pkg::PIN_A_T0] & timer0InMode & syncA[0];
            timer1Input      <= afA_reg[pam_pkg::PIN_A_T1] & timer1InMode & syncA[6];
            uart0ClearToSend <= afA_reg[3] & syncA[3];
            uart0Receive     <= afA_reg[4] & syncA[4];
        end
    end

    // Analogue and clock routing flags
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            analogSelB  <= 5'h00;
            vrefSelB    <= 1'b0;
            analogSelC  <= 3'h0;
            vrefSelC    <= 1'b0;
            extClockIn  <= 1'b0;
            extClockSel <= 1'b0;
        end else begin
            analogSelB  <= anB_next;
            vrefSelB    <= vrefB_next;
            analogSelC  <= anC_next;
            vrefSelC    <= vrefC_next;
            extClockIn  <= ext_clock_in_next;
            extClockSel <= clkSel_next;
        end
    end

    // Synchronised pad levels for the general-purpose input registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gpioInA <= pam_pkg::RST_BYTE;
            gpioInB <= pam_pkg::RST_BYTE;
            gpioInC <= pam_pkg::RST_BYTE;
        end else begin
            gpioInA <= syncA;
            gpioInB <= syncB;
            gpioInC <= syncC;
        end
    end

endmodule : pam_port_alt_mux

// ==== design/pam_sync2.sv ====
// Two flip-flop synchroniser for levels arriving from outside the clock domain
`timescale 1ns/1ps
module pam_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stage1_reg <= '0;
            syncOut    <= '0;
        end else begin
            stage1_reg <= asyncIn;
            syncOut    <= stage1_reg;
        end
    end

endmodule : pam_sync2

// ==== test/pam_port_alt_mux_props.sv ====
// Checker of the multiplexer's port behaviour
`timescale 1ns/1ps
module pam_port_alt_mux_props (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Strap and pads
    input wire logic [1:0]  pkgVariant,
    input wire logic [7:0]  padInA,
    input wire logic [7:0]  padInB,
    // Peripheral side
    input wire logic        timer0InMode,
    input wire logic        timer0Input,
    input wire logic        uart0ClearToSend,
    input wire logic        vrefSelB,
    input wire logic        extClockIn
);
    // ----------------------------------------
    // Clocking and handshake steps
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 pready;
    endsequence
    // Pad levels cross two flops and one output register
    a_apb_one_wait: assert property (s_setup |=> s_answer)
        else $error("pready not in second access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata not zero outside answer");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_vref_28pin: assert property (vrefSelB |-> $past(pkgVariant, 3) == pam_pkg::VAR_28PIN)
        else $error("reference routed on wrong package");
    a_extclk_pad: assert property (extClockIn |->
        ($past(pkgVariant, 3) == pam_pkg::VAR_8PIN ? $past(padInA[1], 3) : $past(padInB[3], 3)))
        else $error("clock input not from the selected pad");
    a_cts_pad: assert property (uart0ClearToSend |-> $past(padInA[3], 3))
        else $error("clear-to-send not from pad");
    a_timer_input: assert property (timer0Input |-> $past(padInA[0], 3) && $past(timer0InMode))
        else $error("timer input without pad or mode");
endmodule : pam_port_alt_mux_props

bind pam_port_alt_mux pam_port_alt_mux_props u_props (.*);

// ==== test/testbench.sv ====
// Self-checking bench for the port alternate-function multiplexer
`timescale 1ns/1ps
`define CHK(a, e) begin \
    checkCount++; \
    if ((a) !== (e)) begin \
        errorCnt++; \
        $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
    end \
end
module testbench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, errq;
    logic [7:0]  paddr, padInA, padInB, padInC, padOutA, padOutB, padOutC;
    logic [31:0] pwdata, prdata, rdq;
    logic [1:0]  pkgVariant;
    logic [7:0]  padOeNA, padOeNB, padOeNC, gpioInA, gpioInB, gpioInC;
    logic [7:0]  gpioOutA, gpioOeNA, gpioOutB, gpioOeNB, gpioOutC, gpioOeNC;
    logic        timer0Output, timer0OutComp, timer0InMode, timer0Input;
    logic        timer1Output, timer1OutComp, timer1InMode, timer1Input;
    logic        uart0DriverEnable, uart0Transmit, uart0ClearToSend, uart0Receive;
    logic [2:0]  ledSinkOn, analogSelC;
    logic [4:0]  analogSelB;
    logic        vrefSelB, vrefSelC, extClockIn, extClockSel;
    int          errorCnt, checkCount, cycles;

    pam_port_alt_mux DUT (.*);

    // Clock at 40 MHz
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            printVerdict();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic printVerdict();
        $display("checks %0d mismatches %0d", checkCount, errorCnt);
        if (errorCnt == 0 && checkCount > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : printVerdict

    // One APB transfer; waits for pready, never assumes its latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errorCnt++;
            printVerdict();
        end
        rdq  = prdata;
        errq = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    // Pads need three edges, so four covers every mux path
    task automatic settle();
        repeat (4) @(posedge clk_sys);
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        settle();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        `CHK(rdq, e)
    endtask : rd

    task automatic doReset(input logic [1:0] v);
        rst        <= 1'b1;
        pkgVariant <= v;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
    endtask : doReset

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, padInA, padInB, padInC} <= '0;
        {gpioOutA, gpioOeNA, gpioOutB, gpioOeNB, gpioOutC, gpioOeNC, ledSinkOn} <= '0;
        {timer0Output, timer0OutComp, timer0InMode, timer1Output, timer1OutComp} <= '0;
        {timer1InMode, uart0DriverEnable, uart0Transmit} <= '0;
        doReset(pam_pkg::VAR_20PIN);
        // Reset values, byte-wide storage, read-only and unmapped places
        for (int i = 0; i < 7; i++)
            rd(8'(4 * i), pam_pkg::ZERO_WORD);
        rd(pam_pkg::ADDR_PADS, pam_pkg::ZERO_WORD);
        wr(pam_pkg::ADDR_C_SEL_HI, 32'hFFFF_FFA5);
        rd(pam_pkg::ADDR_C_SEL_HI, 32'h0000_00A5);
        wr(pam_pkg::ADDR_STATUS, 32'h0000_00FF);
        rd(pam_pkg::ADDR_STATUS, 32'h0000_0010);
        apb(1'b0, 8'h24, 32'h0000_0000);
        `CHK(errq, 1'b1)
        $display("test registers done");
        // Port A: enable alone routes, pins 0 and 6 follow timer mode
        {timer0Output, timer0OutComp, uart0DriverEnable, timer1Output} <= 4'hF;
        wr(pam_pkg::ADDR_A_AF, 32'h0000_00FF);
        `CHK(padOeNA, 8'h18)
        `CHK(padOutA & 8'hE7, 8'h87)
        {timer0Output, timer0OutComp, uart0DriverEnable, timer1Output} <= 4'h0;
        {uart0Transmit, timer1OutComp} <= 2'h3;
        settle();
        `CHK(padOutA & 8'hE7, 8'h60)
        {timer0InMode, timer1InMode, padInA} <= {2'h3, 8'h59};
        settle();
        `CHK(padOeNA, 8'h59)
        `CHK({timer0Input, timer1Input, uart0ClearToSend, uart0Receive}, 4'hF)
        {gpioOutA, gpioOeNA} <= {8'h3C, 8'h5A};
        wr(pam_pkg::ADDR_A_AF, pam_pkg::ZERO_WORD);
        `CHK({padOutA, padOeNA}, 16'h3C5A)
        `CHK({timer0Input, uart0ClearToSend, uart0Receive}, 3'h0)
        $display("test port A done");
        // Port B: low set-select chooses, high one ignored, clock on pin 3
        {padInB, gpioOutB} <= {8'h08, 8'hC3};
        wr(pam_pkg::ADDR_B_SEL_LO, 32'h0000_000F);
        wr(pam_pkg::ADDR_B_AF, 32'h0000_003F);
        `CHK(analogSelB, 5'h0F)
        wr(pam_pkg::ADDR_B_SEL_HI, 32'h0000_00FF);
        `CHK({analogSelB, extClockSel}, 6'h1E)
        wr(pam_pkg::ADDR_B_SEL_LO, 32'h0000_0030);
        `CHK({analogSelB, padOeNB[2:0]}, 8'h87)
        `CHK({extClockSel, extClockIn, vrefSelB}, 3'h6)
        // Synchronised pad levels reach the pad register and the GPIO input side
        rd(pam_pkg::ADDR_PADS, 32'h0000_0859);
        `CHK({gpioInA, gpioInB, gpioInC}, 24'h590800)
        rd(pam_pkg::ADDR_STATUS, 32'h0000_0011);
        wr(pam_pkg::ADDR_B_AF, pam_pkg::ZERO_WORD);
        `CHK({analogSelB, extClockSel, padOutB, padOeNB}, 22'h00C300)
        $display("test port B done");
        // Reference on 28-pin, port C analogue and LED drive
        doReset(pam_pkg::VAR_28PIN);
        wr(pam_pkg::ADDR_B_SEL_LO, 32'h0000_0020);
        wr(pam_pkg::ADDR_B_AF, 32'h0000_0020);
        `CHK(vrefSelB, 1'b1)
        wr(pam_pkg::ADDR_C_SEL_LO, 32'h0000_0007);
        wr(pam_pkg::ADDR_C_AF, 32'h0000_0007);
        `CHK({analogSelC, vrefSelC}, 4'hE)
        ledSinkOn <= 3'h2;
        settle();
        `CHK({analogSelC, padOutC[1], padOeNC[1]}, 5'h14)
        wr(pam_pkg::ADDR_C_SEL_LO, pam_pkg::ZERO_WORD);
        `CHK(analogSelC, 3'h0)
        doReset(pam_pkg::VAR_20PIN);
        wr(pam_pkg::ADDR_C_SEL_LO, 32'h0000_0004);
        wr(pam_pkg::ADDR_C_AF, 32'h0000_0004);
        `CHK({analogSelC, vrefSelC}, 4'h9)
        // Eight-pin part takes the clock from port A pin 1
        doReset(pam_pkg::VAR_8PIN);
        padInA <= 8'h02;
        wr(pam_pkg::ADDR_A_AF, 32'h0000_0002);
        `CHK({extClockSel, extClockIn, padOeNA[1]}, 3'h7)
        $display("test analogue and clock done");
        printVerdict();
    end
endmodule : testbench
